/* File: shared/bsgas_defines.svh */
`ifndef BSGAS_DEFINES_SVH
`define BSGAS_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define BSGAS_OFF_CTRL     8'h00
`define BSGAS_OFF_GPIO_OUT 8'h04
`define BSGAS_OFF_STATUS   8'h08
`define BSGAS_OFF_IRQ_STAT 8'h0c
`define BSGAS_OFF_IRQ_MASK 8'h10

// ==========================================================
// Field positions
`define BSGAS_CTRL_MODE_LSB 0
`define BSGAS_CTRL_CAL_GO   3
`define BSGAS_CTRL_CAL_STOP 4
`define BSGAS_ST_PIN_LSB    0
`define BSGAS_ST_BACKUP     3
`define BSGAS_ST_PRESENT    4
`define BSGAS_ST_CAL_LSB    5
`define BSGAS_ST_NOBUS      7
`define BSGAS_ST_ADDR_LSB   8
`define BSGAS_IRQ_BK_IN     0
`define BSGAS_IRQ_BK_OUT    1
`define BSGAS_IRQ_CAL_DONE  2
`define BSGAS_IRQ_DIS_END   3
`define BSGAS_IRQ_FAULT     4
`define BSGAS_IRQ_W         5

// ==========================================================
// Reset values and bus addresses
`define BSGAS_MODE_RST     3'h0
`define BSGAS_MODE_NOBUS   3'h7
`define BSGAS_GPIO_OUT_RST 3'h7
`define BSGAS_IRQ_RST      5'h00
`define BSGAS_ADDR_GND     7'h12
`define BSGAS_ADDR_VDD     7'h28
`define BSGAS_ADDR_VREF    7'h20

// ==========================================================
// Timing
`define BSGAS_CLK_NS        25
`define BSGAS_TICK_NS       1000
`define BSGAS_TICK_CYC      (`BSGAS_TICK_NS / `BSGAS_CLK_NS)
`define BSGAS_DLY_MIN_TICKS 8'h01

`endif

/* File: shared/bsgas_pkg.sv */
package bsgas_pkg;

  // Decoded level of the address strap
  typedef enum logic [1:0] {
    STRAP_GND,
    STRAP_VDD,
    STRAP_VREF,
    STRAP_HALF
  } bsgas_strap_t;

  // Calibration progress
  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_RUN,
    CAL_DONE
  } bsgas_cal_t;

endpackage : bsgas_pkg

/* File: design/bsgas_gpio_cell.sv */
`timescale 1ns/1ps

// One open-drain pin: status function or host-driven port
module bsgas_gpio_cell (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic status_mode,
  input  wire logic host_out,
  input  wire logic status_on,
  input  wire logic pin_i,
  output logic      pin_o,
  output logic      pin_oe,
  output logic      pin_level
);

  logic pin_oe_ff;

  // ==========================================================
  // Drive: low only, never high (open drain)
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_oe_ff <= 1'b0;
    end else if (status_mode) begin
      pin_oe_ff <= status_on;
    end else begin
      pin_oe_ff <= ~host_out;
    end
  end

  // Sampled pin level for the host read
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_level <= 1'b1;
    end else begin
      pin_level <= pin_i;
    end
  end

  assign pin_o  = 1'b0;
  assign pin_oe = pin_oe_ff;

endmodule : bsgas_gpio_cell

/* File: design/bsgas_present_delay.sv */
`timescale 1ns/1ps
`include "bsgas_defines.svh"

// Delays only the assertion of supply present; loss is immediate
module bsgas_present_delay (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       tick,
  input  wire logic       present,
  input  wire logic       delay_open,
  input  wire logic [7:0] delay_ticks,
  output logic            present_dly
);

  logic [7:0] cnt_ff;
  logic [7:0] limit;

  // Open pin or zero code both give the shortest delay
  assign limit = (delay_open || delay_ticks == 8'h00) ?
                 `BSGAS_DLY_MIN_TICKS : delay_ticks;

  // ==========================================================
  // Tick counter, restarted whenever the supply drops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff      <= 8'h00;
      present_dly <= 1'b0;
    end else if (!present) begin
      cnt_ff      <= 8'h00;
      present_dly <= 1'b0;
    end else if (tick && !present_dly) begin
      if (cnt_ff + 8'h01 >= limit) begin
        present_dly <= 1'b1;
      end
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

endmodule : bsgas_present_delay

/* File: design/bsgas_top.sv */
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "bsgas_defines.svh"

// Operation
// - Strap level picks bus address 12h/28h/20h
// - Half-reference strap: no bus, status pins
// - Pin one: host port or charging status
// - No bus: pin one shows charging
// - Pin two: host port or backup undervoltage
// - No bus: pin two shows undervoltage
// - Pin three: host port or calibration done
// - No bus: pin three shows charge fault
// - Supply present low when sense and lockout ok
// - Delay present assertion; open pin gives minimum
// - Shutdown high: off or register reset
// - Backup when divided supply below threshold
// - Battery gate only in backup mode
// - Discharge limit turns battery gate off; default if grounded
// - Calibration limit ends calibration; default if grounded
// - Reverse current ends calibration unless disabled
// - Supply gate on whenever not in backup
// - Bus commands act regardless of battery type
module bsgas_top (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic [1:0]  bus_address_strap,
  output logic [6:0]       slave_address,
  output logic             no_bus_option,
  input  wire logic        divided_supply_sense,
  input  wire logic        undervoltage_lockout,
  input  wire logic        shutdown_reset_in,
  input  wire logic        delay_pin_open,
  input  wire logic [7:0]  supply_present_delay,
  output logic             supply_present_n_o,
  output logic             supply_present_n_oe,
  output logic             shutdown_mode,
  output logic             backup_mode,
  output logic             battery_switch_gate,
  output logic             supply_switch_gate,
  input  wire logic        discharge_pin_grounded,
  input  wire logic        bat_below_prog_discharge,
  input  wire logic        bat_below_default_discharge,
  input  wire logic        cal_pin_grounded,
  input  wire logic        bat_at_prog_cal,
  input  wire logic        bat_at_default_cal,
  input  wire logic        reverse_sense_grounded,
  input  wire logic        reverse_near,
  output logic             calibrating,
  input  wire logic        charge_phase_active,
  input  wire logic        lead_acid_type,
  input  wire logic        lead_above_cx,
  input  wire logic        charge_fault,
  input  wire logic        gp_pin_one_i,
  output logic             gp_pin_one_o,
  output logic             gp_pin_one_oe,
  input  wire logic        gp_pin_two_i,
  output logic             gp_pin_two_o,
  output logic             gp_pin_two_oe,
  input  wire logic        gp_pin_three_i,
  output logic             gp_pin_three_o,
  output logic             gp_pin_three_oe
);

  logic                    rst_meta_ff;
  logic                    rst_n;
  logic                    init_done_ff;
  logic                    reg_clr;
  logic [5:0]              tick_cnt_ff;
  logic                    tick;
  logic [2:0]              mode_ff;
  logic [2:0]              gpio_out_ff;
  logic [`BSGAS_IRQ_W-1:0] irq_stat_ff;
  logic [`BSGAS_IRQ_W-1:0] irq_mask_ff;
  logic [`BSGAS_IRQ_W-1:0] irq_evt;
  logic [6:0]              addr_ff;
  logic                    no_bus_ff;
  bsgas_pkg::bsgas_cal_t   cal_ff;
  bsgas_pkg::bsgas_cal_t   nxt_cal;
  logic                    dis_end_ff;
  logic                    backup_ff;
  logic                    fault_ff;
  logic                    present_raw;
  logic                    present_dly;
  logic                    bat_at_dis;
  logic                    cal_at_limit;
  logic                    rev_stop;
  logic                    wr_en;
  logic                    rd_setup;
  logic                    addr_ok;
  logic                    cal_go;
  logic                    cal_stop;
  logic [2:0]              status_on;
  logic [2:0]              pin_level;
  logic [31:0]             rd_mux;

  // ==========================================================
  // Reset release through two flops
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_ff <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n       <= rst_meta_ff;
    end
  end

  // Shutdown high with supply present clears the mode, output, calibration and interrupt registers
  assign present_raw = divided_supply_sense & ~undervoltage_lockout;
  assign reg_clr     = shutdown_reset_in & present_raw;

  // ==========================================================
  // One microsecond tick for the present delay
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_ff <= 6'h00;
    end else if (tick) begin
      tick_cnt_ff <= 6'h00;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 6'h01;
    end
  end

  assign tick = (tick_cnt_ff == 6'(`BSGAS_TICK_CYC - 1));

  // ==========================================================
  // Strap capture after reset; also redone after a register clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      init_done_ff <= 1'b0;
      addr_ff      <= `BSGAS_ADDR_GND;
      no_bus_ff    <= 1'b0;
    end else if (reg_clr) begin
      init_done_ff <= 1'b0;
    end else if (!init_done_ff) begin
      init_done_ff <= 1'b1;
      no_bus_ff    <= 1'b0;
      case (bsgas_pkg::bsgas_strap_t'(bus_address_strap))
        bsgas_pkg::STRAP_GND:  addr_ff <= `BSGAS_ADDR_GND;
        bsgas_pkg::STRAP_VDD:  addr_ff <= `BSGAS_ADDR_VDD;
        bsgas_pkg::STRAP_VREF: addr_ff <= `BSGAS_ADDR_VREF;
        bsgas_pkg::STRAP_HALF: begin
          addr_ff   <= `BSGAS_ADDR_GND;
          no_bus_ff <= 1'b1;
        end
        default: addr_ff <= `BSGAS_ADDR_GND;
      endcase
    end
  end

  assign slave_address = addr_ff;
  assign no_bus_option = no_bus_ff;

  // ==========================================================
  // APB decode; bus writes are never gated by battery type
  assign wr_en    = psel & penable & pwrite & addr_ok;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = psel & penable;
  assign pslverr  = psel & penable & ~addr_ok;
  assign cal_go   = wr_en && paddr == `BSGAS_OFF_CTRL &&
                    pwdata[`BSGAS_CTRL_CAL_GO];
  assign cal_stop = wr_en && paddr == `BSGAS_OFF_CTRL &&
                    pwdata[`BSGAS_CTRL_CAL_STOP];

  always_comb begin
    addr_ok = 1'b1;
    rd_mux  = 32'h0000_0000;
    case (paddr)
      `BSGAS_OFF_CTRL:     rd_mux[2:0] = mode_ff;
      `BSGAS_OFF_GPIO_OUT: rd_mux[2:0] = gpio_out_ff;
      `BSGAS_OFF_STATUS: begin
        rd_mux[`BSGAS_ST_PIN_LSB +: 3] = pin_level;
        rd_mux[`BSGAS_ST_BACKUP]       = backup_ff;
        rd_mux[`BSGAS_ST_PRESENT]      = present_dly;
        rd_mux[`BSGAS_ST_CAL_LSB +: 2] = cal_ff;
        rd_mux[`BSGAS_ST_NOBUS]        = no_bus_ff;
        rd_mux[`BSGAS_ST_ADDR_LSB +: 7] = addr_ff;
      end
      `BSGAS_OFF_IRQ_STAT: rd_mux[`BSGAS_IRQ_W-1:0] = irq_stat_ff;
      `BSGAS_OFF_IRQ_MASK: rd_mux[`BSGAS_IRQ_W-1:0] = irq_mask_ff;
      default: addr_ok = 1'b0;
    endcase
  end

  // Read data flopped in the setup phase, ready in the access phase
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  // ==========================================================
  // Pin mode and host output bits; no-bus strap loads status mode at capture
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff     <= `BSGAS_MODE_RST;
      gpio_out_ff <= `BSGAS_GPIO_OUT_RST;
    end else if (reg_clr) begin
      mode_ff     <= `BSGAS_MODE_RST;
      gpio_out_ff <= `BSGAS_GPIO_OUT_RST;
    end else if (!init_done_ff) begin
      if (bsgas_pkg::bsgas_strap_t'(bus_address_strap) ==
          bsgas_pkg::STRAP_HALF) begin
        mode_ff <= `BSGAS_MODE_NOBUS;
      end
    end else if (wr_en && paddr == `BSGAS_OFF_CTRL) begin
      mode_ff <= pwdata[`BSGAS_CTRL_MODE_LSB +: 3];
    end else if (wr_en && paddr == `BSGAS_OFF_GPIO_OUT) begin
      gpio_out_ff <= pwdata[2:0];
    end
  end

  // ==========================================================
  // Backup follows the divided sense and the lockout
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      backup_ff <= 1'b0;
    end else begin
      backup_ff <= ~present_raw;
    end
  end

  // Grounded limit pins fall back to the default comparators
  assign bat_at_dis = discharge_pin_grounded ?
                      bat_below_default_discharge :
                      bat_below_prog_discharge;
  assign cal_at_limit = cal_pin_grounded ? bat_at_default_cal :
                        bat_at_prog_cal;
  assign rev_stop = reverse_near & ~reverse_sense_grounded;

  // Battery isolated once drained; rearmed when backup ends
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dis_end_ff <= 1'b0;
    end else if (!backup_ff) begin
      dis_end_ff <= 1'b0;
    end else if (bat_at_dis) begin
      dis_end_ff <= 1'b1;
    end
  end

  // ==========================================================
  // Switch gates; battery off outside backup to stop back-drive
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      battery_switch_gate <= 1'b0;
      supply_switch_gate  <= 1'b0;
      shutdown_mode       <= 1'b0;
    end else begin
      shutdown_mode       <= shutdown_reset_in & ~present_raw;
      battery_switch_gate <= backup_ff & ~dis_end_ff &
                             ~shutdown_reset_in;
      supply_switch_gate  <= ~backup_ff;
    end
  end

  assign backup_mode = backup_ff;

  // ==========================================================
  // Calibration sequence; backup or a clear cancels it
  always_comb begin
    nxt_cal = cal_ff;
    case (cal_ff)
      bsgas_pkg::CAL_IDLE: begin
        if (cal_go && !backup_ff) begin
          nxt_cal = bsgas_pkg::CAL_RUN;
        end
      end
      bsgas_pkg::CAL_RUN: begin
        if (backup_ff || cal_stop) begin
          nxt_cal = bsgas_pkg::CAL_IDLE;
        end else if (cal_at_limit || rev_stop) begin
          nxt_cal = bsgas_pkg::CAL_DONE;
        end
      end
      bsgas_pkg::CAL_DONE: begin
        if (cal_go && !backup_ff) begin
          nxt_cal = bsgas_pkg::CAL_RUN;
        end
      end
      default: nxt_cal = bsgas_pkg::CAL_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cal_ff <= bsgas_pkg::CAL_IDLE;
    end else if (reg_clr) begin
      cal_ff <= bsgas_pkg::CAL_IDLE;
    end else begin
      cal_ff <= nxt_cal;
    end
  end

  assign calibrating = (cal_ff == bsgas_pkg::CAL_RUN);

  // ==========================================================
  // Status functions of the three pins
  always_comb begin
    status_on[0] = charge_phase_active |
                   (lead_acid_type & lead_above_cx);
    status_on[1] = backup_ff & bat_at_dis;
    status_on[2] = no_bus_ff ? charge_fault :
                   (cal_ff == bsgas_pkg::CAL_DONE);
  end

  bsgas_gpio_cell u_pin_one (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .status_mode (mode_ff[0]),
    .host_out    (gpio_out_ff[0]),
    .status_on   (status_on[0]),
    .pin_i       (gp_pin_one_i),
    .pin_o       (gp_pin_one_o),
    .pin_oe      (gp_pin_one_oe),
    .pin_level   (pin_level[0])
  );

  bsgas_gpio_cell u_pin_two (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .status_mode (mode_ff[1]),
    .host_out    (gpio_out_ff[1]),
    .status_on   (status_on[1]),
    .pin_i       (gp_pin_two_i),
    .pin_o       (gp_pin_two_o),
    .pin_oe      (gp_pin_two_oe),
    .pin_level   (pin_level[1])
  );

  bsgas_gpio_cell u_pin_three (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .status_mode (mode_ff[2]),
    .host_out    (gpio_out_ff[2]),
    .status_on   (status_on[2]),
    .pin_i       (gp_pin_three_i),
    .pin_o       (gp_pin_three_o),
    .pin_oe      (gp_pin_three_oe),
    .pin_level   (pin_level[2])
  );

  // ==========================================================
  // Supply present: open drain low after the programmed delay
  bsgas_present_delay u_present (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .tick        (tick),
    .present     (present_raw),
    .delay_open  (delay_pin_open),
    .delay_ticks (supply_present_delay),
    .present_dly (present_dly)
  );

  assign supply_present_n_o  = 1'b0;
  assign supply_present_n_oe = present_dly;

  // ==========================================================
  // Interrupt events; a set in the clear cycle wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fault_ff <= 1'b0;
    end else begin
      fault_ff <= charge_fault;
    end
  end

  always_comb begin
    irq_evt = '0;
    irq_evt[`BSGAS_IRQ_BK_IN]    = ~present_raw & ~backup_ff;
    irq_evt[`BSGAS_IRQ_BK_OUT]   = present_raw & backup_ff;
    irq_evt[`BSGAS_IRQ_CAL_DONE] = calibrating &
                                   (nxt_cal == bsgas_pkg::CAL_DONE);
    irq_evt[`BSGAS_IRQ_DIS_END]  = backup_ff & bat_at_dis & ~dis_end_ff;
    irq_evt[`BSGAS_IRQ_FAULT]    = charge_fault & ~fault_ff;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_ff <= `BSGAS_IRQ_RST;
      irq_mask_ff <= `BSGAS_IRQ_RST;
    end else if (reg_clr) begin
      irq_stat_ff <= `BSGAS_IRQ_RST;
      irq_mask_ff <= `BSGAS_IRQ_RST;
    end else begin
      if (wr_en && paddr == `BSGAS_OFF_IRQ_STAT) begin
        irq_stat_ff <= (irq_stat_ff & ~pwdata[`BSGAS_IRQ_W-1:0]) |
                       irq_evt;
      end else begin
        irq_stat_ff <= irq_stat_ff | irq_evt;
      end
      if (wr_en && paddr == `BSGAS_OFF_IRQ_MASK) begin
        irq_mask_ff <= pwdata[`BSGAS_IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

endmodule : bsgas_top

/* File: tb/bsgas_props.sv */
`timescale 1ns/1ps

// ==========================================================
// Port checker for the status and gate face
module bsgas_props (
  input wire logic       mclk,
  input wire logic       arst_n,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [6:0] slave_address,
  input wire logic       no_bus_option,
  input wire logic       divided_supply_sense,
  input wire logic       undervoltage_lockout,
  input wire logic       shutdown_reset_in,
  input wire logic       delay_pin_open,
  input wire logic [7:0] supply_present_delay,
  input wire logic       supply_present_n_oe,
  input wire logic       backup_mode,
  input wire logic       battery_switch_gate,
  input wire logic       supply_switch_gate,
  input wire logic       cal_pin_grounded,
  input wire logic       bat_at_default_cal,
  input wire logic       calibrating
);
  logic [2:0]  up_ff;
  logic [13:0] run_ff;
  logic        pr;
  logic [7:0]  nt;

  // Raw presence; a zero or open delay means one tick
  assign pr = divided_supply_sense & ~undervoltage_lockout;
  assign nt = (delay_pin_open || supply_present_delay == 8'h00) ?
              8'h01 : supply_present_delay;

  // Internal reset lags release, so wait before judging entry
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) up_ff <= 3'h0;
    else if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
  end

  // Run length of present supply; soft clear restarts it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) run_ff <= 14'h0;
    else if (!pr || shutdown_reset_in) run_ff <= 14'h0;
    else if (run_ff != 14'h3fff) run_ff <= run_ff + 14'h1;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_loss;
    up_ff == 3'h7 && $fell(pr) && !shutdown_reset_in;
  endsequence

  a_apb_zero_wait: assert property (
    psel && penable |-> pready) else $error("pready missing");
  a_err_in_access: assert property (
    pslverr |-> psel && penable) else $error("stray pslverr");
  a_nobus_addr: assert property (
    no_bus_option |-> slave_address == 7'h12) else $error("no-bus addr");
  a_backup_entry: assert property (
    s_loss |-> ##[1:2] backup_mode) else $error("backup late");
  a_present_loss: assert property (
    s_loss |-> ##[1:2] !supply_present_n_oe) else $error("present held");
  a_delay_min: assert property (
    $rose(supply_present_n_oe) |-> int'(run_ff) + 2 > (int'(nt) - 1) * 40)
    else $error("present too early");
  a_delay_max: assert property (
    int'(run_ff) == int'(nt) * 40 + 6 |-> supply_present_n_oe)
    else $error("present too late");
  a_bat_gate_backup: assert property (
    battery_switch_gate |-> $past(backup_mode)) else $error("bat gate");
  a_supply_gate_off: assert property (
    supply_switch_gate |-> !$past(backup_mode)) else $error("both gates");
  a_supply_gate_back: assert property (
    $fell(backup_mode) && !shutdown_reset_in |=> supply_switch_gate)
    else $error("supply gate off");
  a_cal_limit_stop: assert property (
    calibrating && cal_pin_grounded && bat_at_default_cal
    |-> ##[1:3] !calibrating) else $error("cal past limit");
  a_cal_backup_abort: assert property (
    $rose(backup_mode) |-> ##[0:2] !calibrating) else $error("cal kept");
endmodule : bsgas_props

bind bsgas_top bsgas_props i_bsgas_props (.*);

/* File: tb/bsgas_board.sv */
`timescale 1ns/1ps

// ==========================================================
// Board side: pull-ups and outside parts pulling pins low
module bsgas_board (
  input  wire logic [2:0] oe,
  input  wire logic [2:0] ext_low,
  output logic      [2:0] pin
);
  // Wired-AND; a released pin floats high, never holds its last value
  assign pin = ~(oe | ext_low);
endmodule : bsgas_board

/* File: tb/backup_status_gpio_address_select_tb_top.sv */
`timescale 1ns/1ps

// ==========================================================
// Self-checking bench
module backup_status_gpio_address_select_tb_top;
  logic        mclk = 1'b0, arst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, supply_present_delay = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r = 32'h2b86;
  logic [1:0]  bus_address_strap = 2'h0;
  logic [2:0]  ext_low = 3'h0;
  logic [64:0] q[$], e;
  logic [6:0]  ad[4] = '{7'h12, 7'h28, 7'h20, 7'h12}, slave_address;
  logic divided_supply_sense = 1'b1, undervoltage_lockout = 1'b0;
  logic shutdown_reset_in = 1'b0, delay_pin_open = 1'b0;
  logic discharge_pin_grounded = 1'b0, bat_below_prog_discharge = 1'b0;
  logic bat_below_default_discharge = 1'b0, cal_pin_grounded = 1'b0;
  logic bat_at_prog_cal = 1'b0, bat_at_default_cal = 1'b0;
  logic reverse_sense_grounded = 1'b0, reverse_near = 1'b0;
  logic charge_phase_active = 1'b0, lead_acid_type = 1'b0;
  logic lead_above_cx = 1'b0, charge_fault = 1'b0;
  logic pready, pslverr, irq, no_bus_option, supply_present_n_o;
  logic supply_present_n_oe, shutdown_mode, backup_mode, calibrating;
  logic battery_switch_gate, supply_switch_gate;
  logic gp_pin_one_o, gp_pin_one_oe, gp_pin_two_o, gp_pin_two_oe;
  logic gp_pin_three_o, gp_pin_three_oe;
  logic gp_pin_one_i, gp_pin_two_i, gp_pin_three_i;
  int   n_fail = 0, checks = 0;

  bsgas_top i_bsgas_top (.*);
  bsgas_board i_bsgas_board (
    .oe      ({gp_pin_three_oe, gp_pin_two_oe, gp_pin_one_oe}),
    .ext_low (ext_low),
    .pin     ({gp_pin_three_i, gp_pin_two_i, gp_pin_one_i})
  );

  // 40 MHz clock
  always #12.5 mclk = ~mclk;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx

  task automatic cy(input int n);
    repeat (n) @(posedge mclk);
  endtask : cy

  task automatic chk(input string n, input logic [32:0] s, x);
    checks++;
    if (s !== x) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", n, x, s);
    end
  endtask : chk

  task automatic end_sim;
    if (n_fail == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // One APB transfer; held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Note {mask, pslverr, data} before the read goes out
  task automatic rd(input logic [7:0] a, input logic [32:0] x,
                    input logic [31:0] m);
    q.push_back({m, x});
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Strap is a level, so it is set while reset holds
  task automatic rst(input logic [1:0] s);
    arst_n <= 1'b0;
    bus_address_strap <= s;
    cy(10);
    arst_n <= 1'b1;
    cy(8);
  endtask : rst

  // Read results are judged where they appear
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = q.pop_front();
      chk("apb read", {pslverr, prdata & e[64:33]}, e[32:0]);
    end
  end

  // Cut a hang short
  initial begin
    cy(20000);
    n_fail++;
    end_sim();
  end

  // ==========================================================
  // Scenarios
  initial begin
    for (int s = 0; s < 4; s++) begin
      rst(2'(s));
      rd(8'h08, {18'h0, ad[s], s == 3, 7'h0}, 32'h7f80);
      rd(8'h00, {30'h0, s == 3 ? 3'h7 : 3'h0}, 32'h7);
    end
    for (int i = 0; i < 4; i++) begin
      r = nx(r);
      lead_acid_type <= r[0];
      charge_phase_active <= r[2];
      lead_above_cx <= r[1];
      cy(3);
      chk("pin one", gp_pin_one_oe, r[2] | r[0] & r[1]);
    end
    charge_fault <= 1'b1;
    cy(3);
    chk("pin three", gp_pin_three_oe, 1'b1);
    apb(1'b1, 8'h00, 32'hf);
    divided_supply_sense <= 1'b0;
    cy(4);
    chk("backup", backup_mode, 1'b1);
    chk("bat gate", battery_switch_gate, 1'b1);
    chk("pin two", gp_pin_two_oe, 1'b0);
    bat_below_prog_discharge <= 1'b1;
    cy(4);
    chk("pin two", gp_pin_two_oe, 1'b1);
    chk("bat gate", battery_switch_gate, 1'b0);
    bat_below_prog_discharge <= 1'b0;
    divided_supply_sense <= 1'b1;
    cy(4);
    chk("sup gate", supply_switch_gate, 1'b1);
    rd(8'h0c, 33'h3, 32'h3);
    // Host port: out bit low pulls pin, read shows wired level
    rst(2'h0);
    apb(1'b1, 8'h00, 32'h0);
    for (int i = 0; i < 3; i++) begin
      r = nx(r);
      apb(1'b1, 8'h04, {29'h0, r[2:0]});
      ext_low <= r[5:3];
      cy(3);
      chk("host oe", {gp_pin_three_oe, gp_pin_two_oe, gp_pin_one_oe},
          {30'h0, ~r[2:0]});
      rd(8'h08, {30'h0, r[2:0] & ~r[5:3]}, 32'h7);
    end
    cal_pin_grounded <= 1'b1;
    apb(1'b1, 8'h00, 32'hc);
    cy(2);
    chk("cal", calibrating, 1'b1);
    bat_at_default_cal <= 1'b1;
    cy(4);
    chk("cal", calibrating, 1'b0);
    chk("pin three", gp_pin_three_oe, 1'b1);
    rd(8'h08, 33'h40, 32'h60);
    bat_at_default_cal <= 1'b0;
    reverse_near <= 1'b1;
    reverse_sense_grounded <= 1'b1;
    apb(1'b1, 8'h00, 32'hc);
    cy(4);
    chk("cal", calibrating, 1'b1);
    reverse_sense_grounded <= 1'b0;
    cy(4);
    chk("cal", calibrating, 1'b0);
    // Interrupt: raise, mask, clear; plus an unmapped offset
    apb(1'b1, 8'h10, 32'h4);
    cy(1);
    chk("irq", irq, 1'b1);
    apb(1'b1, 8'h10, 32'h0);
    cy(1);
    chk("irq", irq, 1'b0);
    apb(1'b1, 8'h10, 32'h4);
    apb(1'b1, 8'h0c, 32'h4);
    cy(1);
    chk("irq", irq, 1'b0);
    rd(8'h14, {1'b1, 32'h0}, 32'hffffffff);
    apb(1'b1, 8'h04, 32'h0);
    shutdown_reset_in <= 1'b1;
    cy(3);
    shutdown_reset_in <= 1'b0;
    cy(4);
    rd(8'h00, 33'h0, 32'h7);
    rd(8'h04, 33'h7, 32'h7);
    divided_supply_sense <= 1'b0;
    shutdown_reset_in <= 1'b1;
    cy(4);
    chk("shutdown", shutdown_mode, 1'b1);
    shutdown_reset_in <= 1'b0;
    divided_supply_sense <= 1'b1;
    supply_present_delay <= 8'h03;
    undervoltage_lockout <= 1'b1;
    cy(4);
    chk("present", supply_present_n_oe, 1'b0);
    undervoltage_lockout <= 1'b0;
    cy(78);
    chk("present", supply_present_n_oe, 1'b0);
    cy(50);
    chk("present", supply_present_n_oe, 1'b1);
    delay_pin_open <= 1'b1;
    undervoltage_lockout <= 1'b1;
    cy(4);
    undervoltage_lockout <= 1'b0;
    cy(50);
    chk("present", supply_present_n_oe, 1'b1);
    chk("od low", {supply_present_n_o, gp_pin_three_o, gp_pin_two_o,
        gp_pin_one_o}, 33'h0);
    cy(2);
    end_sim();
  end
endmodule : backup_status_gpio_address_select_tb_top
